//--- design/byte_bit_op_decoder.v
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "bbop_consts.vh"

// Notes on behaviour
// RQ1: One 14-bit word splits into opcode and operands
// RQ2: Dest bit zero writes accumulator, one writes file
// RQ3: Seven-bit file address, 0x00 to 0x7F
// RQ4: Three-bit field picks bit to clear/set/test
// RQ5: File always read, modified, then written back; the code writes it back only for dest bit one and bit clear/set
// RQ6: One cycle; skip adds a NOP cycle
// RQ7: Instruction cycle is four clock periods
// RQ8: Don't-care bits never change decoding
// RQ9: Software must not issue reserved opcodes
// RQ10: Add and subtract update C, DC, Z
// RQ11: AND, OR, XOR update only Z
// RQ12: Increment and decrement update only Z
// RQ13: Inc/dec skip on zero, no flags
// RQ14: Rotates through carry, only C affected
// RQ15: Nibble swap, no flags changed
// RQ16: Complement to destination, Z only
// RQ17: Copy file to destination, Z only
// RQ18: Clear file (bit7=1) or accumulator, Z set
// RQ19: Accumulator copied to file, no flags
// RQ20: NOP pattern changes nothing in one cycle
// RQ21: Bit clear/set in one cycle, no flags
// RQ22: Bit test skips next on clear/set
// RQ23: Skipped instruction makes no writes
module byte_bit_op_decoder (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [7:0]  pc_ff,
    input  wire [13:0] instr_word,
    output reg         cycle_strobe_ff
);
    localparam ST_FETCH = 4'b0001;
    localparam ST_READ  = 4'b0010;
    localparam ST_EXEC  = 4'b0100;
    localparam ST_WRITE = 4'b1000;

    reg [3:0]          state_ff;
    reg [`PHASE_W-1:0] phase_ff;
    reg [13:0]         ir_ff;
    reg [7:0]          acc_ff;
    reg [2:0]          status_ff;
    reg                skip_ff;
    reg [1:0]          ctrl_ff;
    reg [13:0]         sw_instr_ff;
    reg [31:0]         retired_ff;
    reg                aw_hold_ff;
    reg                w_hold_ff;
    reg [11:0]         awaddr_ff;
    reg [31:0]         wdata_ff;
    reg                rd_pend_ff;
    reg [11:0]         araddr_ff;
    reg                wstrb0_ff;

    reg  [7:0]         result;
    reg  [2:0]         nxt_status;
    reg                wr_file;
    reg                wr_acc;
    reg                do_skip;
    reg  [8:0]         sum9;
    reg  [4:0]         sum5;

    wire [7:0]         fdata;
    wire [5:0]         op6   = ir_ff[13:8];                 // RQ1
    wire [3:0]         op4   = ir_ff[13:10];
    wire               dbit  = ir_ff[7];                    // RQ2
    wire [6:0]         faddr = ir_ff[6:0];                  // RQ3
    wire [2:0]         bsel  = ir_ff[9:7];                  // RQ4
    wire               run   = ctrl_ff[`CTRL_RUN_BIT];

    // One-hot bit mask for the bit-oriented group
    function [7:0] bit_mask;
        input [2:0] sel;
        begin
            bit_mask = 8'h01 << sel;
        end
    endfunction

    function is_file_addr;
        input [11:0] a;
        begin
            is_file_addr = (a[11:9] == 3'h1);
        end
    endfunction

    wire               aw_ok   = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    wire               sw_file = aw_ok && is_file_addr(awaddr_ff) && state_ff == ST_FETCH
                                 && !run;
    wire [6:0]         ram_wa  = sw_file ? awaddr_ff[8:2] : faddr;
    wire [7:0]         ram_wd  = sw_file ? wdata_ff[7:0] : result;
    wire               ram_we  = sw_file || (state_ff == ST_WRITE && wr_file && !skip_ff);
    // Bus read address goes straight to the memory at the handshake, so its
    // registered output already holds the byte when the answer is formed
    wire               ar_take = s_axi_arvalid && s_axi_arready;
    wire [6:0]         ar_word = ar_take ? s_axi_araddr[8:2] : araddr_ff[8:2];
    wire [6:0]         ram_ra  = (state_ff == ST_FETCH && !run) ? ar_word : ir_ff[6:0];

    bbop_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_wa),
        .wdata (ram_wd),
        .raddr (ram_ra),
        .rdata (fdata)
    );

    // Datapath: operand is the file value read in ST_READ
    always @* begin
        result     = fdata;
        nxt_status = status_ff;
        wr_file    = 1'b0;
        wr_acc     = 1'b0;
        do_skip    = 1'b0;
        sum9       = 9'h000;
        sum5       = 5'h00;
        if (ir_ff[13:12] == 2'b00) begin
            wr_file = dbit;                                  // RQ2
            wr_acc  = !dbit;
            case (op6)
                `OP_ADD: begin
                    sum9 = {1'b0, fdata} + {1'b0, acc_ff};
                    sum5 = {1'b0, fdata[3:0]} + {1'b0, acc_ff[3:0]};
                    result = sum9[7:0];
                    nxt_status[`FLAG_C]  = sum9[8];          // RQ10
                    nxt_status[`FLAG_DC] = sum5[4];
                end
                `OP_SUB: begin
                    sum9 = {1'b0, fdata} + {1'b0, ~acc_ff} + 9'h001;
                    sum5 = {1'b0, fdata[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;
                    result = sum9[7:0];
                    nxt_status[`FLAG_C]  = sum9[8];          // RQ10
                    nxt_status[`FLAG_DC] = sum5[4];
                end
                `OP_AND:  result = acc_ff & fdata;          // RQ11
                `OP_IOR:  result = acc_ff | fdata;          // RQ11
                `OP_XOR:  result = acc_ff ^ fdata;          // RQ11
                `OP_INC:  result = fdata + 8'h01;           // RQ12
                `OP_DEC:  result = fdata - 8'h01;           // RQ12
                `OP_INCSZ: begin
                    result  = fdata + 8'h01;
                    do_skip = (result == 8'h00);            // RQ13
                end
                `OP_DECSZ: begin
                    result  = fdata - 8'h01;
                    do_skip = (result == 8'h00);            // RQ13
                end
                `OP_RLC: begin
                    result = {fdata[6:0], status_ff[`FLAG_C]};
                    nxt_status[`FLAG_C] = fdata[7];         // RQ14
                end
                `OP_RRC: begin
                    result = {status_ff[`FLAG_C], fdata[7:1]};
                    nxt_status[`FLAG_C] = fdata[0];         // RQ14
                end
                `OP_SWAP: result = {fdata[3:0], fdata[7:4]}; // RQ15
                `OP_COM:  result = ~fdata;                  // RQ16
                `OP_COPY_FILE: result = fdata;              // RQ17
                `OP_CLEAR: begin
                    result = 8'h00;                          // RQ18
                end
                `OP_MOVE_MISC: begin
                    result  = acc_ff;                        // RQ19
                    wr_file = dbit;
                    wr_acc  = 1'b0;                          // RQ20
                end
                default: begin
                    wr_file = 1'b0;
                    wr_acc  = 1'b0;
                end
            endcase
            case (op6)
                `OP_ADD, `OP_SUB, `OP_AND, `OP_IOR, `OP_XOR, `OP_INC, `OP_DEC,
                `OP_COM, `OP_COPY_FILE, `OP_CLEAR:
                    nxt_status[`FLAG_Z] = (result == 8'h00);
                default: nxt_status[`FLAG_Z] = status_ff[`FLAG_Z];
            endcase
        end else if (ir_ff[13:12] == 2'b01) begin
            // Don't-care bits of each pattern are never examined
            case (op4)                                       // RQ8
                `BOP_CLR: begin
                    result  = fdata & ~bit_mask(bsel);      // RQ21
                    wr_file = 1'b1;
                end
                `BOP_SET: begin
                    result  = fdata | bit_mask(bsel);       // RQ21
                    wr_file = 1'b1;
                end
                `BOP_TSTC: do_skip = ~|(fdata & bit_mask(bsel)); // RQ22
                `BOP_TSTS: do_skip = |(fdata & bit_mask(bsel));  // RQ22
                default: do_skip = 1'b0;
            endcase
        end
    end

    // Core sequencer: one phase per clock, four per instruction cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            state_ff        <= ST_FETCH;
            phase_ff        <= {`PHASE_W{1'b0}};
            ir_ff           <= 14'h0000;
            acc_ff          <= `RST_ACC;
            status_ff       <= `RST_STATUS;
            skip_ff         <= 1'b0;
            pc_ff           <= `RST_PC;
            cycle_strobe_ff <= 1'b0;
            retired_ff      <= 32'h0000_0000;
            ctrl_ff         <= 2'b00;
            sw_instr_ff     <= 14'h0000;
        end else begin
            cycle_strobe_ff <= 1'b0;
            if (aw_ok && !is_file_addr(awaddr_ff)) begin
                if (awaddr_ff == `ADDR_CTRL && wstrb0_ff) begin
                    ctrl_ff <= wdata_ff[1:0];
                end
                if (awaddr_ff == `ADDR_INSTR) begin
                    sw_instr_ff <= wdata_ff[13:0];
                end
                if (awaddr_ff == `ADDR_ACC && state_ff == ST_FETCH && !run) begin
                    acc_ff <= wdata_ff[7:0];
                end
            end
            if (run || ctrl_ff[`CTRL_SINGLE_BIT] || state_ff != ST_FETCH) begin
                phase_ff <= phase_ff + 2'h1;                 // RQ7
                case (state_ff)
                    ST_FETCH: begin
                        ir_ff    <= run ? instr_word : sw_instr_ff;
                        state_ff <= ST_READ;
                    end
                    ST_READ: state_ff <= ST_EXEC;            // RQ5
                    ST_EXEC: state_ff <= ST_WRITE;
                    ST_WRITE: begin
                        state_ff        <= ST_FETCH;
                        // Marks the last of the four phases of the cycle
                        cycle_strobe_ff <= (phase_ff == {`PHASE_W{1'b1}});   // RQ7
                        retired_ff      <= retired_ff + 32'h1;
                        // A software write to the control word in this clock wins
                        if (!(aw_ok && awaddr_ff == `ADDR_CTRL && wstrb0_ff)) begin
                            ctrl_ff[`CTRL_SINGLE_BIT] <= 1'b0;
                        end
                        if (skip_ff) begin
                            skip_ff <= 1'b0;                 // RQ23
                        end else begin
                            if (wr_acc) acc_ff <= result;    // RQ2
                            status_ff <= nxt_status;
                            skip_ff   <= do_skip;            // RQ6
                        end
                        pc_ff <= pc_ff + 8'h01;
                    end
                    default: state_ff <= ST_FETCH;
                endcase
            end
        end
    end

    // AXI4-Lite slave; accumulator and file writes and file reads honoured only while core idle
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
            aw_hold_ff    <= 1'b0;
            w_hold_ff     <= 1'b0;
            awaddr_ff     <= 12'h000;
            wdata_ff      <= 32'h0000_0000;
            wstrb0_ff     <= 1'b0;
            rd_pend_ff    <= 1'b0;
            araddr_ff     <= 12'h000;
        end else begin
            s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                // Strobe is W payload: keep it until the write is applied
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (aw_ok) begin
                aw_hold_ff   <= 1'b0;
                w_hold_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_ff[11:5] == 7'h00 || is_file_addr(awaddr_ff))
                                ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !rd_pend_ff && !s_axi_rvalid && !s_axi_arready
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pend_ff <= 1'b1;
                araddr_ff  <= {s_axi_araddr[11:2], 2'b00};
            end
            // One-cycle pending lets the file memory register its read data
            if (rd_pend_ff && !s_axi_rvalid && s_axi_arready == 1'b0) begin
                rd_pend_ff   <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (araddr_ff)
                    `ADDR_CTRL:   s_axi_rdata <= {30'h0, ctrl_ff};
                    `ADDR_ACC:    s_axi_rdata <= {24'h0, acc_ff};
                    `ADDR_STATUS: s_axi_rdata <= {24'h0, pc_ff[7:0] & 8'h00 | {4'h0, skip_ff,
                                                   status_ff}};
                    `ADDR_INSTR:  s_axi_rdata <= {18'h0, sw_instr_ff};
                    `ADDR_INFO:   s_axi_rdata <= retired_ff;
                    default: begin
                        if (is_file_addr(araddr_ff)) begin
                            s_axi_rdata <= {24'h0, fdata};
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= 2'b10;
                        end
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- design/bbop_consts.vh
`ifndef BBOP_CONSTS_VH
`define BBOP_CONSTS_VH

// Register map (byte addresses)
`define ADDR_CTRL        12'h000
`define ADDR_ACC         12'h004
`define ADDR_STATUS      12'h008
`define ADDR_INSTR       12'h00c
`define ADDR_INFO        12'h010
`define ADDR_FILE_BASE   12'h200

// Control bits
`define CTRL_RUN_BIT     0
`define CTRL_SINGLE_BIT  1

// Status flag positions
`define FLAG_C           0
`define FLAG_DC          1
`define FLAG_Z           2

// Reset values
`define RST_ACC          8'h00
`define RST_STATUS       3'h0
`define RST_PC           8'h00

// Timing
`define PHASES_PER_CYCLE 4
`define PHASE_W          2

// Instruction fields
`define INSTR_W          14
`define FADDR_W          7

// Byte-oriented opcodes, bits 13:8
`define OP_MOVE_MISC     6'h00
`define OP_CLEAR         6'h01
`define OP_SUB           6'h02
`define OP_DEC           6'h03
`define OP_IOR           6'h04
`define OP_AND           6'h05
`define OP_XOR           6'h06
`define OP_ADD           6'h07
`define OP_COPY_FILE     6'h08
`define OP_COM           6'h09
`define OP_INC           6'h0a
`define OP_DECSZ         6'h0b
`define OP_RRC           6'h0c
`define OP_RLC           6'h0d
`define OP_SWAP          6'h0e
`define OP_INCSZ         6'h0f

// Bit-oriented groups, bits 13:10
`define BOP_CLR          4'h4
`define BOP_SET          4'h5
`define BOP_TSTC         4'h6
`define BOP_TSTS         4'h7

`endif

//--- design/bbop_ram.v
`include "bbop_consts.vh"

module bbop_ram (
    input  wire                  clk,
    input  wire                  we,
    input  wire [`FADDR_W-1:0]   waddr,
    input  wire [7:0]            wdata,
    input  wire [`FADDR_W-1:0]   raddr,
    output reg  [7:0]            rdata
);
    reg [7:0] mem [0:(1<<`FADDR_W)-1];

    // No reset: contents are undefined after power-up, as in real storage
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- bench/byte_bit_op_decoder_properties.sv
module bbop_props (
    input logic        clk,
    input logic        rst_n,
    input logic        s_axi_awready,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [7:0]  pc_ff,
    input logic        cycle_strobe_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_gap;
        !cycle_strobe_ff [*3];
    endsequence
    property p_strobe_gap;
        cycle_strobe_ff |=> s_gap;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("cycle strobe too close");
    property p_pc_step;
        pc_ff != $past(pc_ff) |-> pc_ff == $past(pc_ff) + 8'h01;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc moved by other than one");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("rvalid not two cycles after ar");
    property p_aw_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready held two cycles");
    property p_ar_pulse;
        s_axi_arready |=> !s_axi_arready;
    endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("arready held two cycles");
    property p_b_after;
        $rose(s_axi_bvalid) |-> $past(s_axi_wready, 2) || $past(s_axi_awready, 2);
    endproperty
    a_b_after: assert property (p_b_after) else $error("bvalid without a taken write");
endmodule

bind byte_bit_op_decoder bbop_props u_props (.clk, .rst_n, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pc_ff, .cycle_strobe_ff);

//--- bench/prog_rom.sv
module prog_rom (
    input  logic [7:0]  pc,
    output logic [13:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] mem [0:255];
    initial begin
        // Unused space holds the defined no-operation only
        for (int i = 0; i < 256; i++) mem[i] = 14'h0000;
        mem[0] = 14'h0aa0;
        mem[1] = 14'h1c20;
        mem[2] = 14'h0aa0;
        mem[3] = 14'h0aa0;
    end
    assign word = mem[pc];
endmodule

//--- bench/byte_bit_op_decoder_tb.sv
`include "bbop_consts.vh"
module byte_bit_op_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [7:0]  pc_ff;
    wire  [13:0] instr_word;
    wire         cycle_strobe_ff;
    logic [31:0] rdat;
    logic [1:0]  rsp;
    logic [1:0]  wrsp;
    int          fail_count = 0;
    int          comparisons = 0;
    int          t;

    always #12.5 clk = ~clk;

    byte_bit_op_decoder dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_ff, .instr_word,
        .cycle_strobe_ff);
    prog_rom u_rom (.pc(pc_ff), .word(instr_word));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wrsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rdat, e);
        chk({30'h0, rsp}, 32'h0);
    endtask

    function automatic logic [11:0] fa(input logic [6:0] f);
        return `ADDR_FILE_BASE + {3'b000, f, 2'b00};
    endfunction

    task wait_strobe;
        t = 0;
        while (cycle_strobe_ff !== 1'b1 && t < 40) begin
            @(posedge clk);
            t++;
        end
        chk(t < 40, 32'h1);
    endtask

    // Preload, single-step one word, then check accumulator, file byte and flags
    task ex(input logic [7:0] acc, input logic [7:0] fv, input logic [13:0] ins,
            input logic [7:0] ea, input logic [7:0] ef, input logic [3:0] es);
        wr(`ADDR_ACC, {24'h0, acc});
        wr(fa(ins[6:0]), {24'h0, fv});
        wr(`ADDR_INSTR, {18'h0, ins});
        wr(`ADDR_CTRL, 32'h2);
        wait_strobe;
        rchk(`ADDR_ACC, {24'h0, ea});
        rchk(fa(ins[6:0]), {24'h0, ef});
        rchk(`ADDR_STATUS, {28'h0, es});
    endtask

    task finish_test;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test;
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rchk(`ADDR_CTRL, 32'h0);
        rchk(`ADDR_ACC, 32'h0);
        rchk(`ADDR_STATUS, 32'h0);
        rd(12'h100);
        chk(rdat, 32'h0);
        chk({30'h0, rsp}, 32'h2);
        wr(12'h104, 32'h5a);
        chk({30'h0, wrsp}, 32'h2);
        // Control byte lane disabled: the write must not start a step
        s_axi_wstrb <= 4'he;
        wr(`ADDR_CTRL, 32'h2);
        s_axi_wstrb <= 4'hf;
        rchk(`ADDR_CTRL, 32'h0);
        ex(8'h17, 8'hc2, 14'h0710, 8'hd9, 8'hc2, 4'h0);
        ex(8'h05, 8'h05, 14'h02ff, 8'h05, 8'h00, 4'h7);
        ex(8'h17, 8'hc2, 14'h0590, 8'h17, 8'h02, 4'h3);
        ex(8'h00, 8'h00, 14'h0410, 8'h00, 8'h00, 4'h7);
        ex(8'hff, 8'h0f, 14'h0610, 8'hf0, 8'h0f, 4'h3);
        ex(8'h00, 8'hff, 14'h0a90, 8'h00, 8'h00, 4'h7);
        ex(8'h33, 8'h01, 14'h0310, 8'h00, 8'h01, 4'h7);
        ex(8'h33, 8'h13, 14'h0910, 8'hec, 8'h13, 4'h3);
        ex(8'h33, 8'h00, 14'h0810, 8'h00, 8'h00, 4'h7);
        ex(8'h00, 8'h01, 14'h0c90, 8'h00, 8'h80, 4'h7);
        ex(8'h00, 8'h40, 14'h0d10, 8'h81, 8'h40, 4'h6);
        ex(8'h01, 8'h00, 14'h0610, 8'h01, 8'h00, 4'h2);
        ex(8'h00, 8'ha5, 14'h0e90, 8'h00, 8'h5a, 4'h2);
        ex(8'h12, 8'h5a, 14'h0190, 8'h12, 8'h00, 4'h6);
        ex(8'h5a, 8'h77, 14'h017f, 8'h00, 8'h77, 4'h6);
        ex(8'h3c, 8'h00, 14'h0090, 8'h3c, 8'h3c, 4'h6);
        ex(8'h3c, 8'h99, 14'h0060, 8'h3c, 8'h99, 4'h6);
        ex(8'h00, 8'hc7, 14'h1390, 8'h00, 8'h47, 4'h6);
        ex(8'h00, 8'h0a, 14'h1790, 8'h00, 8'h8a, 4'h6);
        ex(8'h00, 8'h02, 14'h1890, 8'h00, 8'h02, 4'h6);
        ex(8'h00, 8'h02, 14'h1c90, 8'h00, 8'h02, 4'he);
        ex(8'h11, 8'h22, 14'h0790, 8'h11, 8'h22, 4'h6);
        ex(8'h00, 8'h01, 14'h0b90, 8'h00, 8'h00, 4'he);
        ex(8'h00, 8'h05, 14'h0a90, 8'h00, 8'h05, 4'h6);
        ex(8'h55, 8'hff, 14'h0f10, 8'h00, 8'hff, 4'he);
        ex(8'h55, 8'h0f, 14'h0990, 8'h55, 8'h0f, 4'h6);
        ex(8'h00, 8'hfe, 14'h1810, 8'h00, 8'hfe, 4'he);
        ex(8'h77, 8'h00, 14'h0090, 8'h77, 8'h00, 4'h6);
        rchk(`ADDR_INFO, 32'h1c);
        chk(pc_ff, 32'h1c);
        // Second reset so the free-running program starts at address zero
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wr(fa(7'h20), 32'h0);
        chk({30'h0, wrsp}, 32'h0);
        wr(`ADDR_CTRL, 32'h1);
        wait_strobe;
        @(posedge clk);
        wait_strobe;
        chk(t, 32'h3);
        repeat (24) @(posedge clk);
        wr(`ADDR_CTRL, 32'h0);
        repeat (8) @(posedge clk);
        rchk(fa(7'h20), 32'h2);
        rchk(`ADDR_STATUS, 32'h0);
        finish_test;
    end
endmodule
